/* rtl/spisf_core.sv */
// Holds the APB slave, flags, two-deep receive FIFO and a mode-0 MSB-first shifter.
// Assumes pin inputs are asynchronous to MCLK; vector acknowledge is a one-cycle pulse.
`timescale 1ns/1ps
module spisf_core (
   input wire logic MCLK, // Peripheral clock
   input wire logic SYS_RST, // Async reset, active high
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB access phase
   input wire logic PWRITE, // APB direction
   input wire logic [spisf_pkg::SPISF_ADDR_W-1:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error on unmapped address
   input wire logic IRQ_ACK, // Vector executed pulse
   output logic IRQ, // Interrupt request
   input wire logic SCK_IN, // Serial clock from a master peer
   output logic SCK_OUT, // Serial clock when master
   input wire logic MISO_IN, // Serial data in, master
   input wire logic MOSI_IN, // Serial data in, slave
   output logic SDO, // Serial data out
   input wire logic SS_N // Slave select input, active low
);
   import spisf_pkg::*;

   logic [7:0] ctrl, mode, irqen;
   logic rx_ready_flag, tx_drained_flag, tx_buffer_empty_flag, select_trigger_flag;
   logic receive_overrun_flag, xfer_done_flag, write_collision_flag;
   logic [7:0] fifo [SPISF_FIFO_DEPTH];
   logic [1:0] fifo_cnt;
   logic [7:0] tx_buf, shreg;
   logic [3:0] bit_cnt;
   logic [7:0] half_cnt;
   logic ovf_pend, flag_read_armed;
   spisf_state_t state;
   logic [1:0] sck_s, mosi_s, miso_s, ss_s;
   logic sck_d;

   // Two flops on every pin input
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sck_s <= 2'h0;
         mosi_s <= 2'h0;
         miso_s <= 2'h0;
         ss_s <= 2'h3;
         sck_d <= 1'b0;
      end else begin
         sck_s <= {sck_s[0], SCK_IN};
         mosi_s <= {mosi_s[0], MOSI_IN};
         miso_s <= {miso_s[0], MISO_IN};
         ss_s <= {ss_s[0], SS_N};
         sck_d <= sck_s[1];
      end
   end

   wire enabled = ctrl[SPISF_B_ENABLE];
   wire is_master = ctrl[SPISF_B_MASTER];
   wire buffered_mode_enable = mode[SPISF_B_BUFFERED_MODE_ENABLE];
   wire ss_low = ~ss_s[1];
   wire sel_fault = enabled && is_master && ss_low && !mode[SPISF_B_SELDIS];

   wire [7:0] widx = PADDR[9:2];
   wire mapped = (PADDR[1:0] == 2'h0) && (PADDR[SPISF_ADDR_W-1:10] == '0)
      && (widx <= SPISF_IDX_DATA);
   wire acc = PSEL && PENABLE;
   wire wr = acc && PWRITE && mapped;
   wire rd = acc && !PWRITE && mapped;
   wire wr_flags = wr && (widx == SPISF_IDX_FLAGS);
   wire rd_flags = rd && (widx == SPISF_IDX_FLAGS);
   wire wr_data = wr && (widx == SPISF_IDX_DATA);
   wire rd_data = rd && (widx == SPISF_IDX_DATA);
   wire acc_data = wr_data || rd_data;

   // Shifter events
   wire busy = (state != SPISF_IDLE);
   // A slave frame ends when its select rises, so a cut frame never leaves the shifter busy
   wire frame_cut = !is_master && !ss_low;
   wire s_rise = sck_s[1] && !sck_d;
   wire s_fall = !sck_s[1] && sck_d;
   wire half_tick = (half_cnt == 8'(SPISF_HALF_CYC - 1));
   wire m_lead = is_master && half_tick && state == SPISF_LEAD;
   wire m_trail = is_master && half_tick && state == SPISF_TRAIL;
   wire sample = is_master ? m_lead : (busy && s_rise && ss_low);
   wire shift = is_master ? m_trail : (busy && s_fall && ss_low);
   wire last_bit = (bit_cnt == SPISF_BITS - 4'h1);
   wire byte_done = shift && last_bit;
   wire tx_queued = buffered_mode_enable && !tx_buffer_empty_flag;
   wire plain_start = wr_data && !busy && !buffered_mode_enable;
   wire buf_start = !busy && tx_queued && (is_master || ss_low);
   wire slave_start = !busy && !is_master && enabled && ss_low && !tx_queued;
   wire start = enabled && (plain_start || buf_start || slave_start);
   wire reload = byte_done && tx_queued;
   wire push = byte_done;
   wire pop = rd_data && fifo_cnt != 2'h0;
   wire fifo_full = (fifo_cnt == 2'(SPISF_FIFO_DEPTH));
   wire idle_take = (state == SPISF_IDLE) && start && tx_queued;

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= SPISF_IDLE;
         bit_cnt <= 4'h0;
         half_cnt <= 8'h00;
         shreg <= SPISF_RST_BYTE;
      end else begin
         half_cnt <= (busy && is_master && !half_tick) ? half_cnt + 8'h01 : 8'h00;
         unique case (state)
            SPISF_IDLE: begin
               if (start) begin
                  state <= SPISF_LEAD;
                  bit_cnt <= 4'h0;
                  shreg <= plain_start ? PWDATA[7:0] : (tx_queued ? tx_buf : shreg);
               end
            end
            SPISF_LEAD: begin
               if (sel_fault || !enabled || frame_cut) state <= SPISF_IDLE;
               else if (sample) begin
                  shreg <= {shreg[6:0], is_master ? miso_s[1] : mosi_s[1]};
                  state <= SPISF_TRAIL;
               end
            end
            SPISF_TRAIL: begin
               if (!enabled || frame_cut) state <= SPISF_IDLE;
               else if (shift) begin
                  bit_cnt <= bit_cnt + 4'h1;
                  state <= SPISF_LEAD;
                  if (last_bit) begin
                     state <= reload ? SPISF_LEAD : SPISF_IDLE;
                     bit_cnt <= 4'h0;
                     if (reload) shreg <= tx_buf;
                  end
               end
            end
         endcase
      end
   end

   // MSB first, data changes on the trailing edge of SCK
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         SDO <= 1'b0;
         SCK_OUT <= 1'b0;
      end else begin
         // Shifter advances at the sample point; hold the bit until SCK has fallen
         if (state != SPISF_TRAIL) SDO <= shreg[7];
         SCK_OUT <= is_master && state == SPISF_TRAIL;
      end
   end

   // Control registers; master bit drops on select fault
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl <= SPISF_RST_BYTE;
         mode <= SPISF_RST_BYTE;
         irqen <= SPISF_RST_BYTE;
      end else begin
         if (wr && widx == SPISF_IDX_CTRL) ctrl <= PWDATA[7:0];
         if (wr && widx == SPISF_IDX_MODE) mode <= PWDATA[7:0];
         if (wr && widx == SPISF_IDX_IRQEN) irqen <= PWDATA[7:0];
         if (sel_fault) ctrl[SPISF_B_MASTER] <= 1'b0;
      end
   end

   // Transmit buffer, buffered mode only
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tx_buf <= SPISF_RST_BYTE;
         tx_buffer_empty_flag <= 1'b1;
      end else begin
         if ((idle_take || reload) && !(wr_data && buffered_mode_enable)) tx_buffer_empty_flag <= 1'b1;
         if (wr_data && buffered_mode_enable) begin
            tx_buf <= PWDATA[7:0];
            tx_buffer_empty_flag <= 1'b0;
         end
      end
   end

   // Receive FIFO, oldest at index 0
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         fifo_cnt <= 2'h0;
         for (int i = 0; i < SPISF_FIFO_DEPTH; i++) fifo[i] <= SPISF_RST_BYTE;
      end else begin
         if (pop) begin
            fifo[0] <= fifo[1];
         end
         if (push && !(fifo_full && !pop)) begin
            if (pop) fifo[fifo_cnt[1]] <= shreg;
            else fifo[fifo_cnt[0]] <= shreg;
         end
         if (push && !pop && !fifo_full) fifo_cnt <= fifo_cnt + 2'h1;
         else if (pop && !push) fifo_cnt <= fifo_cnt - 2'h1;
      end
   end

   // Buffered flags, set in buffered mode only, plus the overrun flag, set in either mode; hardware set wins over a write-one or data-read clear
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tx_drained_flag <= 1'b0;
         select_trigger_flag <= 1'b0;
         receive_overrun_flag <= 1'b0;
         ovf_pend <= 1'b0;
      end else begin
         if (wr_flags && PWDATA[SPISF_F_TX]) tx_drained_flag <= 1'b0;
         if (buffered_mode_enable && byte_done && !tx_queued) tx_drained_flag <= 1'b1;
         if (wr_flags && PWDATA[SPISF_F_SS]) select_trigger_flag <= 1'b0;
         if (buffered_mode_enable && sel_fault) select_trigger_flag <= 1'b1;
         if (rd_data) begin
            receive_overrun_flag <= 1'b0;
            ovf_pend <= 1'b0;
         end
         if (push && fifo_full && !pop) begin
            if (tx_queued) receive_overrun_flag <= 1'b1;
            else ovf_pend <= 1'b1;
         end
         if (ovf_pend && start) begin
            receive_overrun_flag <= 1'b1;
            ovf_pend <= 1'b0;
         end
      end
   end

   // Plain flags: read flags with flag set, then a data access clears
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         xfer_done_flag <= 1'b0;
         write_collision_flag <= 1'b0;
         flag_read_armed <= 1'b0;
      end else begin
         if (rd_flags) flag_read_armed <= xfer_done_flag || write_collision_flag;
         else if (acc_data) flag_read_armed <= 1'b0;
         if ((acc_data && flag_read_armed) || IRQ_ACK) xfer_done_flag <= 1'b0;
         if (acc_data && flag_read_armed) write_collision_flag <= 1'b0;
         if (!buffered_mode_enable && (byte_done || sel_fault)) xfer_done_flag <= 1'b1;
         if (!buffered_mode_enable && wr_data && busy) write_collision_flag <= 1'b1;
      end
   end

   assign rx_ready_flag = buffered_mode_enable && fifo_cnt != 2'h0;

   logic [7:0] flags_view;
   always_comb begin
      flags_view = 8'h00;
      if (buffered_mode_enable) begin
         flags_view[SPISF_F_RX] = rx_ready_flag;
         flags_view[SPISF_F_TX] = tx_drained_flag;
         flags_view[SPISF_F_DRE] = tx_buffer_empty_flag;
         flags_view[SPISF_F_SS] = select_trigger_flag;
      end else begin
         flags_view[SPISF_F_RX] = xfer_done_flag;
         flags_view[SPISF_F_TX] = write_collision_flag;
      end
      flags_view[SPISF_F_OVF] = receive_overrun_flag;
   end

   // Interrupt request from enabled flags in the current mode
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) IRQ <= 1'b0;
      else if (buffered_mode_enable)
         IRQ <= (rx_ready_flag && irqen[SPISF_B_RXIE]) || (tx_drained_flag && irqen[SPISF_B_TXIE])
            || (tx_buffer_empty_flag && irqen[SPISF_B_TX_EMPTY_IRQ_ENABLE])
            || (select_trigger_flag && irqen[SPISF_B_SELECT_TRIGGER_IRQ_ENABLE]);
      else IRQ <= xfer_done_flag && irqen[SPISF_B_IE];
   end

   // APB: zero wait state, read data registered in setup phase
   assign PREADY = 1'b1;
   assign PSLVERR = acc && !mapped;
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) PRDATA <= 32'h0000_0000;
      else if (PSEL && !PENABLE && !PWRITE) begin
         unique case (widx)
            SPISF_IDX_CTRL: PRDATA <= {24'h000000, ctrl};
            SPISF_IDX_MODE: PRDATA <= {24'h000000, mode};
            SPISF_IDX_IRQEN: PRDATA <= {24'h000000, irqen};
            SPISF_IDX_FLAGS: PRDATA <= {24'h000000, flags_view};
            SPISF_IDX_DATA: PRDATA <= {24'h000000, fifo[0]};
            default: PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // A received byte that fits must show as unread data on the next cycle
   a_rx_flag: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (buffered_mode_enable && push && !fifo_full && !(wr && widx == SPISF_IDX_MODE)) |=> rx_ready_flag)
      else $error("rx ready not set");
   a_done_set: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (!buffered_mode_enable && byte_done) |=> xfer_done_flag) else $error("done not set");
   a_fault_done: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (!buffered_mode_enable && sel_fault) |=> (xfer_done_flag && !ctrl[SPISF_B_MASTER]))
      else $error("select fault not handled");
   a_ack_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (IRQ_ACK && !byte_done && !sel_fault) |=> !xfer_done_flag) else $error("ack no clear");
   a_col_set: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (!buffered_mode_enable && wr_data && busy) |=> write_collision_flag) else $error("no collision");
   a_dre_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (buffered_mode_enable && wr_data) |=> !tx_buffer_empty_flag) else $error("empty not cleared");
   a_ovf_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (receive_overrun_flag && !rd_data) |=> receive_overrun_flag) else $error("ovf lost");
   // Two plain-mode cycles with no done flag leave nothing that may raise the request
   sequence s_plain_quiet;
      (!buffered_mode_enable && !xfer_done_flag) ##1 !buffered_mode_enable;
   endsequence
   a_irq_plain: assert property (@(posedge MCLK) disable iff (SYS_RST)
      s_plain_quiet |-> !IRQ) else $error("spurious irq");
   a_drain_set: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (buffered_mode_enable && byte_done && !tx_queued) |=> tx_drained_flag) else $error("drain not set");
   a_trig_set: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (buffered_mode_enable && sel_fault) |=> select_trigger_flag) else $error("trigger not set");
   a_ovf_late: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (ovf_pend && start) |=> receive_overrun_flag) else $error("late overrun lost");
   a_dre_take: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (buffered_mode_enable && idle_take && !wr_data) |=> tx_buffer_empty_flag) else $error("empty not set");
endmodule : spisf_core

/* rtl/spisf_pkg.sv */
// Constants shared by the serial port flag and data block.
// Assumes a 32-bit APB master and a peripheral clock of 125 MHz.
package spisf_pkg;
   // Printed offsets are indices; byte address is four times the index
   localparam logic [7:0] SPISF_IDX_CTRL = 8'h00;
   localparam logic [7:0] SPISF_IDX_MODE = 8'h01;
   localparam logic [7:0] SPISF_IDX_IRQEN = 8'h02;
   localparam logic [7:0] SPISF_IDX_FLAGS = 8'h03;
   localparam logic [7:0] SPISF_IDX_DATA = 8'h04;
   localparam int SPISF_ADDR_W = 12;
   // Control fields
   localparam int SPISF_B_ENABLE = 0;
   localparam int SPISF_B_MASTER = 5;
   localparam int SPISF_B_SELDIS = 2;
   localparam int SPISF_B_BUFFERED_MODE_ENABLE = 7;
   localparam int SPISF_B_BUFWR = 6;
   // Interrupt enables
   localparam int SPISF_B_RXIE = 7;
   localparam int SPISF_B_TXIE = 6;
   localparam int SPISF_B_TX_EMPTY_IRQ_ENABLE = 5;
   localparam int SPISF_B_SELECT_TRIGGER_IRQ_ENABLE = 4;
   localparam int SPISF_B_IE = 0;
   // Flag positions
   localparam int SPISF_F_RX = 7;
   localparam int SPISF_F_TX = 6;
   localparam int SPISF_F_DRE = 5;
   localparam int SPISF_F_SS = 4;
   localparam int SPISF_F_OVF = 0;
   localparam logic [7:0] SPISF_RST_BYTE = 8'h00;
   localparam int SPISF_FIFO_DEPTH = 2;
   localparam logic [3:0] SPISF_BITS = 4'h8;
   // Serial clock half period in master mode: 40 ns
   localparam int SPISF_CLK_MHZ = 125;
   localparam int SPISF_HALF_NS = 40;
   localparam int SPISF_HALF_CYC = (SPISF_HALF_NS * SPISF_CLK_MHZ + 999) / 1000;
   typedef enum logic [2:0] {
      SPISF_IDLE = 3'b001,
      SPISF_LEAD = 3'b010,
      SPISF_TRAIL = 3'b100
   } spisf_state_t;
endpackage : spisf_pkg

/* tb/spisf_peer.sv */
// Serial peer model: slave to the block's master clock, master on demand.
// Assumes mode 0, MSB first; the peer's own clock stands still outside frames.
`timescale 1ns/1ps
module spisf_peer (
   input wire logic SCK, // Clock from the block as master
   input wire logic SDI, // Block serial output
   output logic MISO, // Reply to the block
   output logic SCK_M, // Clock when the peer is master
   output logic MOSI, // Data when the peer is master
   output logic SS_N // Select toward the block, active low
);
   logic [7:0] reply;
   logic [7:0] shin;
   logic [7:0] got;
   logic [2:0] cnt;
   initial begin
      reply = 8'h3c;
      cnt = 3'h0;
      SCK_M = 1'b0;
      MOSI = 1'b0;
      SS_N = 1'b1;
   end
   assign MISO = reply[3'h7 - cnt];
   // Each reply differs by 0x11 so FIFO order can be told apart
   always @(posedge SCK) begin
      shin = {shin[6:0], SDI};
      cnt = cnt + 3'h1;
      if (cnt == 3'h0) begin
         got = shin;
         reply = reply + 8'h11;
      end
   end
   task automatic send(input logic [7:0] b);
      // Keep link edges clear of the block's clock edges
      #2;
      for (int i = 7; i >= 0; i--) begin
         MOSI = b[i];
         #40 SCK_M = 1'b1;
         #40 SCK_M = 1'b0;
      end
      // Released line must not keep showing the last bit
      MOSI = ~MOSI;
   endtask : send
endmodule : spisf_peer

/* tb/tb.sv */
// Self-checking bench for the serial flag and data block.
// Assumes the zero-wait APB slave and the peer model in spisf_peer.
`timescale 1ns/1ps
module tb;
   import spisf_pkg::*;
   logic MCLK, SYS_RST, PSEL, PENABLE, PWRITE, IRQ_ACK, rerr;
   logic [SPISF_ADDR_W-1:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rdat;
   logic PREADY, PSLVERR, IRQ, SCK_OUT, SDO, MISO, SCK_M, MOSI, SS_N;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   spisf_core u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .IRQ_ACK(IRQ_ACK), .IRQ(IRQ), .SCK_IN(SCK_M), .SCK_OUT(SCK_OUT),
      .MISO_IN(MISO), .MOSI_IN(MOSI), .SDO(SDO), .SS_N(SS_N));
   spisf_peer u_peer (.SCK(SCK_OUT), .SDI(SDO), .MISO(MISO), .SCK_M(SCK_M), .MOSI(MOSI),
      .SS_N(SS_N));
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   task automatic end_sim();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {2'b00, idx, 2'b00};
      PWDATA <= {24'h000000, wd};
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr
   task automatic rd(input logic [7:0] idx);
      apb(1'b0, idx, 8'h00);
   endtask : rd
   task automatic flag(input int b, input logic e);
      rd(SPISF_IDX_FLAGS);
      cmp({31'h0, rdat[b]}, {31'h0, e});
   endtask : flag
   task automatic wait_irq();
      for (int i = 0; i < 400 && IRQ !== 1'b1; i++) @(posedge MCLK);
      cmp({31'h0, IRQ}, 32'h1);
   endtask : wait_irq
   task automatic t_reset();
      rd(SPISF_IDX_FLAGS);
      cmp(rdat & 32'h000000d1, 32'h0);
      rd(SPISF_IDX_DATA);
      cmp(rdat, 32'h0);
      apb(1'b0, 8'h05, 8'h00);
      cmp({31'h0, rerr}, 32'h1);
      cmp(rdat, 32'h0);
   endtask : t_reset
   task automatic t_plain();
      wr(SPISF_IDX_IRQEN, 8'h01);
      wr(SPISF_IDX_CTRL, 8'h21);
      wr(SPISF_IDX_DATA, 8'ha5);
      wr(SPISF_IDX_DATA, 8'h5a);
      wait_irq();
      cmp({24'h0, u_peer.got}, 32'ha5);
      flag(SPISF_F_RX, 1'b1);
      cmp({31'h0, rdat[SPISF_F_TX]}, 32'h1);
      rd(SPISF_IDX_DATA);
      cmp(rdat & 32'hff, 32'h3c);
      flag(SPISF_F_RX, 1'b0);
      cmp({31'h0, rdat[SPISF_F_TX]}, 32'h0);
      cmp({31'h0, IRQ}, 32'h0);
      wr(SPISF_IDX_DATA, 8'h0f);
      wait_irq();
      IRQ_ACK <= 1'b1;
      @(posedge MCLK);
      IRQ_ACK <= 1'b0;
      repeat (3) @(posedge MCLK);
      cmp({31'h0, IRQ}, 32'h0);
      wr(SPISF_IDX_IRQEN, 8'hf0);
      wr(SPISF_IDX_DATA, 8'h11);
      rdat = 32'h0;
      for (int i = 0; i < 100 && rdat[SPISF_F_RX] !== 1'b1; i++) rd(SPISF_IDX_FLAGS);
      cmp({31'h0, rdat[SPISF_F_RX]}, 32'h1);
      cmp({31'h0, IRQ}, 32'h0);
      rd(SPISF_IDX_DATA);
      wr(SPISF_IDX_IRQEN, 8'h01);
      u_peer.SS_N <= 1'b0;
      wait_irq();
      rd(SPISF_IDX_CTRL);
      cmp({31'h0, rdat[SPISF_B_MASTER]}, 32'h0);
      flag(SPISF_F_RX, 1'b1);
      rd(SPISF_IDX_DATA);
      u_peer.SS_N <= 1'b1;
   endtask : t_plain
   task automatic t_buf();
      wr(SPISF_IDX_MODE, 8'hc0);
      wr(SPISF_IDX_CTRL, 8'h21);
      wr(SPISF_IDX_IRQEN, 8'h40);
      u_peer.reply = 8'h20;
      flag(SPISF_F_DRE, 1'b1);
      wr(SPISF_IDX_DATA, 8'hc3);
      wr(SPISF_IDX_DATA, 8'h3c);
      flag(SPISF_F_DRE, 1'b0);
      wait_irq();
      cmp({24'h0, u_peer.got}, 32'h3c);
      flag(SPISF_F_RX, 1'b1);
      wr(SPISF_IDX_FLAGS, 8'h40);
      flag(SPISF_F_TX, 1'b0);
      wr(SPISF_IDX_DATA, 8'h01);
      wait_irq();
      flag(SPISF_F_OVF, 1'b0);
      wr(SPISF_IDX_FLAGS, 8'h40);
      wr(SPISF_IDX_DATA, 8'h02);
      wait_irq();
      flag(SPISF_F_OVF, 1'b1);
      wr(SPISF_IDX_FLAGS, 8'h40);
      flag(SPISF_F_OVF, 1'b1);
      rd(SPISF_IDX_DATA);
      cmp(rdat & 32'hff, 32'h20);
      rd(SPISF_IDX_DATA);
      cmp(rdat & 32'hff, 32'h31);
      flag(SPISF_F_RX, 1'b0);
      wr(SPISF_IDX_IRQEN, 8'h20);
      wait_irq();
      wr(SPISF_IDX_IRQEN, 8'h00);
      repeat (2) @(posedge MCLK);
      cmp({31'h0, IRQ}, 32'h0);
   endtask : t_buf
   task automatic t_sel();
      wr(SPISF_IDX_FLAGS, 8'h40);
      wr(SPISF_IDX_IRQEN, 8'h90);
      wr(SPISF_IDX_CTRL, 8'h21);
      u_peer.SS_N <= 1'b0;
      wait_irq();
      rd(SPISF_IDX_CTRL);
      cmp({31'h0, rdat[SPISF_B_MASTER]}, 32'h0);
      flag(SPISF_F_SS, 1'b1);
      wr(SPISF_IDX_FLAGS, 8'h10);
      flag(SPISF_F_SS, 1'b0);
      u_peer.send(8'h96);
      wait_irq();
      rd(SPISF_IDX_DATA);
      cmp(rdat & 32'hff, 32'h96);
      u_peer.SS_N <= 1'b1;
      wr(SPISF_IDX_MODE, 8'hc4);
      wr(SPISF_IDX_CTRL, 8'h21);
      u_peer.SS_N <= 1'b0;
      // Absence can only be judged after the select has crossed the synchroniser
      repeat (8) @(posedge MCLK);
      rd(SPISF_IDX_CTRL);
      cmp({31'h0, rdat[SPISF_B_MASTER]}, 32'h1);
      flag(SPISF_F_SS, 1'b0);
      u_peer.SS_N <= 1'b1;
   endtask : t_sel
   initial begin
      SYS_RST = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = '0;
      PWDATA = 32'h0;
      IRQ_ACK = 1'b0;
      repeat (12) @(posedge MCLK);
      SYS_RST <= 1'b0;
      t_reset();
      t_plain();
      t_buf();
      t_sel();
      end_sim();
   end
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end
endmodule : tb
